//--- core/boundary_reg.sv
// boundary register: one capture/shift stage and one update latch per pin
// assumes capture, shift and update arrive as one-cycle pulses
`timescale 1ns/1ns
module boundary_reg
	import tap_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, high
	input wire logic ce, // freezes all state when low
	bsr_if.cells bus, // controller side
	input wire logic [BSR_LEN-1:0] pad_in, // levels seen at the pins
	input wire logic [BSR_LEN-1:0] core_out, // functional pin values
	output logic [BSR_LEN-1:0] pad_out // value driven to the pins
);

	logic [BSR_LEN-1:0] sh_r;
	logic [BSR_LEN-1:0] sh_nxt;
	logic [BSR_LEN-1:0] upd_r;
	logic [BSR_LEN-1:0] upd_nxt;
	logic [BSR_LEN-1:0] pad_r;
	logic [BSR_LEN-1:0] pad_nxt;

	// ------------------------------------------------------------------
	// per-cell next values
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < BSR_LEN; gi++)
		begin : g_cell
			logic shin;
			assign shin = (gi == BSR_LEN - 1) ? bus.ser_in : sh_r[(gi + 1) % BSR_LEN];
			// capture sees the pins even while the core runs
			assign sh_nxt[gi] = bus.capture ? pad_in[gi] : // R4
				(bus.shift ? shin : sh_r[gi]);
			// update loads the latch, also as preload ahead of external test
			assign upd_nxt[gi] = bus.update ? sh_r[gi] : upd_r[gi]; // R5
			// latch owns the pin only in external-test modes
			assign pad_nxt[gi] = bus.drive_pins ? upd_r[gi] : core_out[gi]; // R3
		end
	endgenerate

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sh_r <= '0;
			upd_r <= '0;
			pad_r <= '0;
		end
		else if (ce)
		begin
			sh_r <= sh_nxt;
			upd_r <= upd_nxt;
			pad_r <= pad_nxt;
		end
	end

	assign bus.ser_out = sh_r[0];
	assign pad_out = pad_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_BSR_PRELOAD: assert property (ce && bus.update |=> upd_r == $past(sh_r)) // R5
		else $error("update latch missed shifted data");
	AST_BSR_SAMPLE: assert property (ce && bus.capture |=> sh_r == $past(pad_in)) // R4
		else $error("capture did not take pin levels");

endmodule : boundary_reg

//--- core/bsr_if.sv
// control and serial path between the controller and the boundary cells
// assumes both ends run on the same system clock
`timescale 1ns/1ns
interface bsr_if;
	logic capture;
	logic shift;
	logic update;
	logic ser_in;
	logic ser_out;
	logic drive_pins;

	modport ctrl (output capture, output shift, output update, output ser_in,
		output drive_pins, input ser_out);
	modport cells (input capture, input shift, input update, input ser_in,
		input drive_pins, output ser_out);
endinterface : bsr_if

//--- core/tap_ctrl.sv
// test access port: controller, instruction, bypass and id registers
// assumes tck, tms, tdi and trst_n come from pins, unsynchronised, and
// that tck runs well below a quarter of the system clock rate
`timescale 1ns/1ns
// Functional notes
// R1: five dedicated test pins with scan logic
// R2: bypass gives one-bit path tdi to tdo
// R3: extest lets boundary cells drive pins
// R4: sample captures pins, core undisturbed
// R5: sample also preloads boundary update latches
// R6: clamp selects bypass, cells still drive
// R7: controller rests in reset during functional mode
// R8: reset state forces idcode instruction
// R9: trst_n low resets controller without tck
// R10: 32-bit id register: maker, part, version
// R11: idcode puts id register in path
// R12: capture-dr loads id code under idcode
// R13: bit 0 nearest tdo, shifted first
// R14: standard states; tdo changes on falling tck
module tap_ctrl
	import tap_pkg::*;
#(
	parameter logic [31:0] ID_CODE = ID_CODE_DEF // arbitrary value
)
(
	input wire logic clk, // system clock, 250 MHz
	input wire logic rst, // synchronous reset, high
	input wire logic ce, // freezes all state when low
	input wire logic tck, // test clock pin
	input wire logic tms, // test mode select pin
	input wire logic tdi, // test data in pin
	input wire logic trst_n, // test reset pin, low active
	output logic tdo, // test data out
	output logic tdo_oe, // high while tdo is driven
	input wire logic [BSR_LEN-1:0] pad_in, // pin levels
	input wire logic [BSR_LEN-1:0] core_out, // functional pin values
	output logic [BSR_LEN-1:0] pad_out, // pin values after the cells
	output logic tap_idle // controller in reset state
);

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [SYNC_LEN-1:0] tck_sy_r, tms_sy_r, tdi_sy_r, trst_sy_r;
	logic [SYNC_LEN-1:0] tck_sy_nxt, tms_sy_nxt, tdi_sy_nxt, trst_sy_nxt;
	logic tck_d_r;
	logic tck_s, tms_s, tdi_s, trst_s_n;
	logic rise, fall;

	// bit 0 is the first stage; only bit 1 is read downstream
	always_comb
	begin
		tck_sy_nxt = {tck_sy_r[0], tck}; // R1
		tms_sy_nxt = {tms_sy_r[0], tms};
		tdi_sy_nxt = {tdi_sy_r[0], tdi};
		trst_sy_nxt = {trst_sy_r[0], trst_n};
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tck_sy_r <= '0;
			tms_sy_r <= '1;
			tdi_sy_r <= '0;
			trst_sy_r <= '0;
			tck_d_r <= 1'b0;
		end
		else if (ce)
		begin
			tck_sy_r <= tck_sy_nxt;
			tms_sy_r <= tms_sy_nxt;
			tdi_sy_r <= tdi_sy_nxt;
			trst_sy_r <= trst_sy_nxt;
			tck_d_r <= tck_s;
		end
	end

	assign tck_s = tck_sy_r[1];
	assign tms_s = tms_sy_r[1];
	assign tdi_s = tdi_sy_r[1];
	assign trst_s_n = trst_sy_r[1];
	// tms and tdi share the tck latency, so they line up with the edge
	assign rise = tck_s & ~tck_d_r;
	assign fall = ~tck_s & tck_d_r;

	// ------------------------------------------------------------------
	// controller state
	// ------------------------------------------------------------------
	tap_state_t state_r, state_nxt;

	always_comb
	begin
		state_nxt = state_r;
		if (!trst_s_n)
			state_nxt = ST_TLR; // R9
		else if (rise)
		begin
			unique case (state_r) // R14
				ST_TLR: state_nxt = tms_s ? ST_TLR : ST_RTI; // R7
				ST_RTI: state_nxt = tms_s ? ST_SEL_DR : ST_RTI;
				ST_SEL_DR: state_nxt = tms_s ? ST_SEL_IR : ST_CAP_DR;
				ST_CAP_DR: state_nxt = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
				ST_SHIFT_DR: state_nxt = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
				ST_EXIT1_DR: state_nxt = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
				ST_PAUSE_DR: state_nxt = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
				ST_EXIT2_DR: state_nxt = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
				ST_UPD_DR: state_nxt = tms_s ? ST_SEL_DR : ST_RTI;
				ST_SEL_IR: state_nxt = tms_s ? ST_TLR : ST_CAP_IR;
				ST_CAP_IR: state_nxt = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
				ST_SHIFT_IR: state_nxt = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
				ST_EXIT1_IR: state_nxt = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
				ST_PAUSE_IR: state_nxt = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
				ST_EXIT2_IR: state_nxt = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
				ST_UPD_IR: state_nxt = tms_s ? ST_SEL_DR : ST_RTI;
				// a corrupted one-hot code falls back to the safe state
				default: state_nxt = ST_TLR;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state_r <= ST_TLR;
		else if (ce)
			state_r <= state_nxt;
	end

	assign tap_idle = (state_r == ST_TLR);

	// ------------------------------------------------------------------
	// instruction, bypass, id and tdo
	// ------------------------------------------------------------------
	logic [IR_LEN-1:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
	logic [ID_LEN-1:0] id_sh_r, id_sh_nxt; // R10
	logic byp_r, byp_nxt;
	logic tdo_r, tdo_nxt, oe_r, oe_nxt;
	logic sel_id, sel_bsr, sel_byp, dr_lsb;
	bsr_if bus ();

	// unknown codes fall to bypass so the chain length stays defined
	assign sel_id = (ir_r == OP_IDCODE); // R11
	assign sel_bsr = (ir_r == OP_EXTEST) || (ir_r == OP_SAMPLE);
	assign sel_byp = !sel_id && !sel_bsr; // R6
	assign dr_lsb = sel_id ? id_sh_r[0] : (sel_bsr ? bus.ser_out : byp_r);

	always_comb
	begin
		ir_sh_nxt = ir_sh_r;
		ir_nxt = ir_r;
		id_sh_nxt = id_sh_r;
		byp_nxt = byp_r;
		tdo_nxt = tdo_r;
		oe_nxt = oe_r;
		if (state_r == ST_TLR)
			ir_nxt = OP_IDCODE; // R8
		if (rise && state_r == ST_CAP_IR)
			ir_sh_nxt = IR_CAPTURE;
		if (rise && state_r == ST_SHIFT_IR)
			ir_sh_nxt = {tdi_s, ir_sh_r[IR_LEN-1:1]};
		if (rise && state_r == ST_CAP_DR)
		begin
			byp_nxt = 1'b0; // R2
			id_sh_nxt = ID_CODE; // R12
		end
		if (rise && state_r == ST_SHIFT_DR)
		begin
			byp_nxt = tdi_s; // R2
			// tdi enters at bit 31, bit 0 leaves first
			id_sh_nxt = {tdi_s, id_sh_r[ID_LEN-1:1]}; // R13
		end
		if (fall)
		begin
			if (state_r == ST_UPD_IR)
				ir_nxt = ir_sh_r;
			// output moves only on falling tck, so the tester samples on rising
			tdo_nxt = (state_r == ST_SHIFT_IR) ? ir_sh_r[0] : dr_lsb; // R14
			oe_nxt = (state_r == ST_SHIFT_IR) || (state_r == ST_SHIFT_DR); // R14
		end
		// test reset out of a shift state comes with no falling tck, so release here
		if (state_r == ST_TLR)
			oe_nxt = 1'b0; // R14
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ir_sh_r <= IR_CAPTURE;
			ir_r <= OP_IDCODE;
			id_sh_r <= '0;
			byp_r <= 1'b0;
			tdo_r <= 1'b0;
			oe_r <= 1'b0;
		end
		else if (ce)
		begin
			ir_sh_r <= ir_sh_nxt;
			ir_r <= ir_nxt;
			id_sh_r <= id_sh_nxt;
			byp_r <= byp_nxt;
			tdo_r <= tdo_nxt;
			oe_r <= oe_nxt;
		end
	end

	assign tdo = tdo_r;
	assign tdo_oe = oe_r;

	// ------------------------------------------------------------------
	// boundary register control
	// ------------------------------------------------------------------
	assign bus.capture = rise && state_r == ST_CAP_DR && sel_bsr; // R4
	assign bus.shift = rise && state_r == ST_SHIFT_DR && sel_bsr;
	assign bus.update = fall && state_r == ST_UPD_DR && sel_bsr; // R5
	assign bus.ser_in = tdi_s;
	// clamp keeps cells on the pins while only the bypass bit shifts
	assign bus.drive_pins = (ir_r == OP_EXTEST) || (ir_r == OP_CLAMP); // R3 R6

	boundary_reg u_bsr (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.bus(bus.cells),
		.pad_in(pad_in),
		.core_out(core_out),
		.pad_out(pad_out)
	);

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_TLR_IR: assert property (ce && state_r == ST_TLR |=> ir_r == OP_IDCODE) // R8
		else $error("reset state did not force idcode");
	AST_TRST_ASYNC: assert property (ce && !trst_s_n |=> state_r == ST_TLR) // R9
		else $error("trst_n low did not reset controller");
	AST_BYP_CAP: assert property (ce && rise && state_r == ST_CAP_DR && sel_byp // R2
		|=> !byp_r)
		else $error("bypass bit not cleared on capture");
	AST_ID_CAP: assert property (ce && rise && state_r == ST_CAP_DR // R12
		|=> id_sh_r == ID_CODE)
		else $error("id code not loaded on capture");
	AST_ID_SHIFT: assert property (ce && rise && state_r == ST_SHIFT_DR // R13
		|=> id_sh_r == {$past(tdi_s), $past(id_sh_r[ID_LEN-1:1])})
		else $error("id register shifted the wrong way");
	AST_TDO_FALL_ONLY: assert property (!(ce && fall) |=> $stable(tdo)) // R14
		else $error("tdo moved away from a falling tck");
	AST_OE_SHIFT: assert property (ce && fall && state_r != ST_SHIFT_DR // R14
		&& state_r != ST_SHIFT_IR |=> !tdo_oe)
		else $error("tdo driven outside shift states");
	AST_ID_OUT: assert property (ce && fall && sel_id && state_r == ST_SHIFT_DR // R11
		|=> tdo == $past(id_sh_r[0]))
		else $error("id register not on the serial path");
	AST_CLAMP: assert property (ir_r == OP_CLAMP |-> bus.drive_pins && sel_byp) // R6
		else $error("clamp path wrong");
	AST_EXTEST: assert property (ce && ir_r == OP_EXTEST // R3
		|=> pad_out == $past(u_bsr.upd_r))
		else $error("extest cells not driving pins");
	AST_SAMPLE: assert property (ir_r == OP_SAMPLE |-> !bus.drive_pins) // R4
		else $error("sample disturbed the pins");

	// instruction path, bypass bit, tdo enable, functional pin path and controller sequencing
	AST_OE_TLR: assert property (ce && state_r == ST_TLR |=> !tdo_oe) // R14
		else $error("tdo still driven in reset state");
	AST_IR_CAP: assert property (ce && rise && state_r == ST_CAP_IR // R14
		|=> ir_sh_r == IR_CAPTURE)
		else $error("instruction capture value wrong");
	AST_IR_UPD: assert property (ce && fall && state_r == ST_UPD_IR // R14
		|=> ir_r == $past(ir_sh_r))
		else $error("instruction not taken on update");
	AST_IR_STEADY: assert property (ce && state_r != ST_TLR // R8
		&& !(fall && state_r == ST_UPD_IR) |=> $stable(ir_r))
		else $error("instruction changed outside update");
	AST_IR_OUT: assert property (ce && fall && state_r == ST_SHIFT_IR // R14
		|=> tdo == $past(ir_sh_r[0]))
		else $error("instruction register not on the serial path");
	AST_BYP_SHIFT: assert property (ce && rise && state_r == ST_SHIFT_DR // R2
		|=> byp_r == $past(tdi_s))
		else $error("bypass bit did not take tdi");
	AST_BYP_OUT: assert property (ce && fall && sel_byp && state_r == ST_SHIFT_DR // R2
		|=> tdo == $past(byp_r))
		else $error("bypass bit not on the serial path");
	AST_PAD_FUNC: assert property (ce && !bus.drive_pins // R4
		|=> pad_out == $past(core_out))
		else $error("core lost control of the pins");
	AST_TLR_HOLD: assert property (ce && rise && tms_s && state_r == ST_TLR // R7
		|=> state_r == ST_TLR)
		else $error("controller left reset with tms high");
	AST_PAUSE_HOLD: assert property (ce && rise && !tms_s && state_r == ST_PAUSE_DR // R14
		|=> state_r == ST_PAUSE_DR)
		else $error("controller left pause with tms low");
	AST_ONEHOT: assert property ($onehot(state_r)) // R14
		else $error("controller state not one-hot");

	COV_IDCODE_SHIFT: cover property (sel_id && rise && state_r == ST_SHIFT_DR);
	COV_IR_UPDATE: cover property (fall && state_r == ST_UPD_IR);
	COV_EXTEST_UPD: cover property (bus.update && ir_r == OP_EXTEST);
	COV_TRST: cover property (!trst_s_n ##1 trst_s_n);

endmodule : tap_ctrl

//--- core/tap_pkg.sv
// constants shared by the test access port and its boundary register
// assumes the test pins are sampled by a much faster system clock
package tap_pkg;

	// ------------------------------------------------------------------
	// register lengths
	// ------------------------------------------------------------------
	localparam int IR_LEN = 4;
	localparam int ID_LEN = 32;
	localparam int BSR_LEN = 8;
	localparam int SYNC_LEN = 2;

	// ------------------------------------------------------------------
	// instruction codes and capture values
	// ------------------------------------------------------------------
	localparam logic [3:0] OP_EXTEST = 4'h0;
	localparam logic [3:0] OP_SAMPLE = 4'h1;
	localparam logic [3:0] OP_IDCODE = 4'h2;
	localparam logic [3:0] OP_CLAMP = 4'h3;
	localparam logic [3:0] OP_BYPASS = 4'hF;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	// arbitrary identification value; bit 0 must stay set
	localparam logic [31:0] ID_CODE_DEF = 32'h0F0E_D001;

	// ------------------------------------------------------------------
	// controller states, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [15:0] {
		ST_TLR = 16'h0001,
		ST_RTI = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SHIFT_DR = 16'h0010,
		ST_EXIT1_DR = 16'h0020,
		ST_PAUSE_DR = 16'h0040,
		ST_EXIT2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SHIFT_IR = 16'h0800,
		ST_EXIT1_IR = 16'h1000,
		ST_PAUSE_IR = 16'h2000,
		ST_EXIT2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} tap_state_t;

endpackage : tap_pkg

//--- verification/jtag_tester.sv
// board tester model: drives the four test input pins and collects tdo
// assumes its tasks are called from the system clock domain
`timescale 1ns/1ns
module jtag_tester
(
	input wire logic clk, // system clock
	output logic tck, // test clock, still between frames
	output logic tms, // mode select
	output logic tdi, // serial data into the port
	output logic trst_n, // test reset, low active
	input wire logic tdo, // serial data from the port
	input wire logic tdo_oe // high while tdo is driven
);
	localparam int HALF = 10; // 80 ns test clock at 4 ns

	// ------------------------------------------------------------------
	// pin sequencing
	// ------------------------------------------------------------------
	// reset held low from power-up, clock parked low
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b0;
	end

	// low pulse, then quiet time so the synchroniser sees it before any tck
	task reset_pulse;
		trst_n <= 1'b0;
		repeat (5) @(posedge clk);
		trst_n <= 1'b1;
		repeat (5) @(posedge clk);
	endtask : reset_pulse

	// tdo read just before the rise, long after the fall that set it;
	// a released tdo reads inverted so a missing enable shows as bad data
	task tick(input logic m, input logic d, output logic o, output logic oe);
		@(posedge clk);
		tms <= m;
		tdi <= d;
		repeat (HALF - 1) @(posedge clk);
		o = tdo_oe ? tdo : ~tdo;
		oe = tdo_oe;
		tck <= 1'b1;
		repeat (HALF) @(posedge clk);
		tck <= 1'b0;
	endtask : tick

	// idle to shift state, n bits lsb first, update, back to idle
	task scan(input logic ir, input int n, input logic [63:0] din,
		output logic [63:0] dout, output logic oe_all);
		logic o;
		logic oe;
		dout = '0;
		oe_all = 1'b1;
		tick(1'b1, 1'b0, o, oe);
		if (ir)
			tick(1'b1, 1'b0, o, oe);
		tick(1'b0, 1'b0, o, oe);
		tick(1'b0, 1'b0, o, oe);
		for (int i = 0; i < n; i++)
		begin
			tick(i == n - 1, din[i], o, oe);
			dout[i] = o;
			oe_all &= oe;
		end
		tick(1'b1, 1'b0, o, oe);
		tick(1'b0, 1'b0, o, oe);
	endtask : scan
endmodule : jtag_tester

//--- verification/tap_ctrl_tb.sv
// self-checking bench for the test access port
// assumes the tester model owns the test pins; clock enable is held high
`timescale 1ns/1ns
module tap_ctrl_tb
	import tap_pkg::*;
;
	logic clk = 1'b0;
	logic rst;
	logic ce;
	logic tck;
	logic tms;
	logic tdi;
	logic trst_n;
	logic tdo;
	logic tdo_oe;
	logic tap_idle;
	logic [BSR_LEN-1:0] pad_in;
	logic [BSR_LEN-1:0] core_out;
	logic [BSR_LEN-1:0] pad_out;
	logic [63:0] d;
	logic oe;
	logic o;
	int n_mismatch = 0;
	int compares = 0;

	// ------------------------------------------------------------------
	// clock and instances
	// ------------------------------------------------------------------
	always #2 clk = ~clk;

	jtag_tester far (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
		.tdo(tdo), .tdo_oe(tdo_oe));
	tap_ctrl DUT (.clk(clk), .rst(rst), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi),
		.trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in),
		.core_out(core_out), .pad_out(pad_out), .tap_idle(tap_idle));

	// ------------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------------
	// compare on the falling clock, away from any update
	task check(input logic [63:0] seen, input logic [63:0] exp);
		@(negedge clk);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task stop_test;
		$display("mismatches %0d, compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task load_ir(input logic [3:0] op);
		far.scan(1'b1, 4, {60'h0, op}, d, oe);
		check(d[3:0], IR_CAPTURE);
	endtask : load_ir

	task t_reset;
		check(tap_idle, 1'b1);
		check(tdo_oe, 1'b0);
		far.tick(1'b0, 1'b0, o, oe);
		check(tap_idle, 1'b0);
	endtask : t_reset

	// 64 bits: the code, then what went in at tdi
	task t_idcode;
		far.scan(1'b0, 64, {32'h0000_0000, 32'hC3A5_5A3C}, d, oe);
		check(d[31:0], ID_CODE_DEF);
		check(d[63:32], 32'hC3A5_5A3C);
		check(oe, 1'b1);
		check(tdo_oe, 1'b0);
	endtask : t_idcode

	// an unused code must fall back to the one-bit path too
	task t_bypass;
		logic [3:0] ops [2] = '{OP_BYPASS, 4'h9};
		foreach (ops[k])
		begin
			load_ir(ops[k]);
			far.scan(1'b0, 9, 64'h0B4, d, oe);
			check(d[0], 1'b0);
			check(d[8:1], 8'hB4);
		end
	endtask : t_bypass

	task t_boundary;
		@(posedge clk);
		pad_in <= 8'hA5;
		core_out <= 8'h5A;
		load_ir(OP_SAMPLE);
		far.scan(1'b0, 8, 64'h3C, d, oe);
		check(d[7:0], 8'hA5);
		check(pad_out, 8'h5A);
		load_ir(OP_EXTEST);
		check(pad_out, 8'h3C);
		@(posedge clk);
		pad_in <= 8'h96;
		far.scan(1'b0, 8, 64'hC3, d, oe);
		check(d[7:0], 8'h96);
		check(pad_out, 8'hC3);
		load_ir(OP_CLAMP);
		check(pad_out, 8'hC3);
		far.scan(1'b0, 9, 64'h01E, d, oe);
		check(d[8:1], 8'h1E);
	endtask : t_boundary

	// test reset in mid-shift, with no tck at all
	task t_trst;
		far.tick(1'b1, 1'b0, o, oe);
		far.tick(1'b0, 1'b0, o, oe);
		far.tick(1'b0, 1'b0, o, oe);
		far.reset_pulse;
		check(tap_idle, 1'b1);
		check(pad_out, 8'h5A);
		check(tdo_oe, 1'b0);
		far.tick(1'b0, 1'b0, o, oe);
		far.scan(1'b0, 32, 64'h0, d, oe);
		check(d[31:0], ID_CODE_DEF);
	endtask : t_trst

	// five highs on tms from shift-dr, not four, reach reset
	task t_tms;
		far.tick(1'b1, 1'b0, o, oe);
		far.tick(1'b0, 1'b0, o, oe);
		far.tick(1'b0, 1'b0, o, oe);
		repeat (4) far.tick(1'b1, 1'b0, o, oe);
		check(tap_idle, 1'b0);
		far.tick(1'b1, 1'b0, o, oe);
		check(tap_idle, 1'b1);
	endtask : t_tms

	// id shift paused after four bits resumes at the fifth
	task t_pause;
		logic [7:0] got;
		far.tick(1'b0, 1'b0, o, oe);
		far.tick(1'b1, 1'b0, o, oe);
		repeat (2) far.tick(1'b0, 1'b0, o, oe);
		for (int i = 0; i < 8; i++)
		begin
			far.tick(i == 3 || i == 7, 1'b0, o, oe);
			got[i] = o;
			if (i == 3)
			begin
				repeat (2) far.tick(1'b0, 1'b0, o, oe);
				far.tick(1'b1, 1'b0, o, oe);
				far.tick(1'b0, 1'b0, o, oe);
			end
		end
		far.tick(1'b1, 1'b0, o, oe);
		far.tick(1'b0, 1'b0, o, oe);
		check(got, ID_CODE_DEF[7:0]);
		check(tap_idle, 1'b0);
	endtask : t_pause

	// ------------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		pad_in = 8'h00;
		core_out = 8'h00;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		far.reset_pulse;
		t_reset;
		t_idcode;
		t_bypass;
		t_boundary;
		t_trst;
		t_tms;
		t_pause;
		stop_test;
	end

	// about ten times the expected run
	initial
	begin
		#200000;
		n_mismatch++;
		stop_test;
	end
endmodule : tap_ctrl_tb
